// ---- rtl/mgl_device.sv ----
// device end: register bank for misc control, two general pins and electrode-detect logic
// assumes host keeps its own write rules; pins and comparators are asynchronous inputs
// Notes on behaviour
// - calibration bit seven enables offset calibration
// - bit one selects internal drive reference
// - host writes zeros to misc reserved bits
// - direction bits: zero output, one input
// - pin data reads return actual pin level
// - data write drives level only for outputs
// - host keeps pin register top bits zero
// - select codes six/seven route return input
// - host treats rerouted channel as unusable
// - per-side sensing, excitation separately disableable
// - swap bit reverses source and sink
// - two-bit field sets excitation current
// - three-bit field picks threshold converter level
// - status stored and sent in data stream
// - comparator powerdown bit disables comparators
// - ac excitation alternates at quarter rate
// - host uses power-up check only amp off
// - amp on: sink off, comparator senses
// - host reads status to find side
// - status one means disconnected, resets zero
// - buffer power bit zero means powered down
`timescale 1ns/1ps
`include "mgl_defines.svh"
module mgl_device (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register access
	mgl_if.dev bus,
	// general pins
	input wire logic [1:0] pin_in_i,
	output logic [1:0] pin_out_o,
	output logic [1:0] pin_oe_o,
	// analog comparator results, timing and channel input selects
	input wire logic [3:0] electrode_cmp_i,
	input wire logic drive_cmp_i,
	input wire logic data_ready_i,
	input wire logic [3:0] ch1_select_i,
	input wire logic [3:0] ch2_select_i,
	// analog controls
	output logic offset_cal_enable_o,
	output logic drive_ref_internal_sel_o,
	output logic [3:0] sense_enable_o,
	output logic [3:0] excite_enable_o,
	output logic [1:0] excitation_direction_swap_o,
	output logic [1:0] excitation_current_level_o,
	output logic [2:0] comparator_threshold_sel_o,
	output logic comparator_powerdown_o,
	output logic excite_polarity_o,
	output logic drive_sink_enable_o,
	output logic [1:0] ch1_route_o,
	output logic [1:0] ch2_route_o,
	// data stream status words
	output logic [7:0] stream_status_o,
	output logic [7:0] stream_control_o
);
	import mgl_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		mgl_byte_t misc;
		mgl_byte_t pins;
		mgl_byte_t sense;
		mgl_byte_t drive;
		mgl_byte_t cfg2;
		mgl_byte_t det;
		mgl_byte_t status;
		logic [2:0][1:0] pin_sync;
		logic [2:0][4:0] cmp_sync;
		logic [1:0] pin_level;
		logic [4:0] cmp_level;
		logic [1:0] ac_cnt;
		logic ac_phase;
		mgl_byte_t rdata;
		logic rvalid;
		logic [1:0] pin_out;
		logic [1:0] pin_oe;
		logic [3:0] sense_en;
		logic [3:0] excite_en;
		logic sink_en;
		logic [1:0] r1;
		logic [1:0] r2;
	} mgl_dev_s;

	mgl_dev_s q;
	mgl_dev_s next_q;

	// ==========================================
	// next state
	always_comb begin
		next_q = q;
		// three-stage sync; a change counts once stages two and three agree
		next_q.pin_sync[0] = pin_in_i;
		next_q.pin_sync[1] = q.pin_sync[0];
		next_q.pin_sync[2] = q.pin_sync[1];
		if (q.pin_sync[1] == q.pin_sync[2]) begin
			next_q.pin_level = q.pin_sync[2];
		end
		next_q.cmp_sync[0] = {drive_cmp_i, electrode_cmp_i};
		next_q.cmp_sync[1] = q.cmp_sync[0];
		next_q.cmp_sync[2] = q.cmp_sync[1];
		if (q.cmp_sync[1] == q.cmp_sync[2]) begin
			next_q.cmp_level = q.cmp_sync[2];
		end
		// comparators powered down hold status at lead-on
		if (q.cfg2[`MGL_CFG2_CMP_PD_BIT]) begin
			next_q.status = 8'h00;
		end else begin
			next_q.status = {3'h0, q.cmp_level} & `MGL_STATUS_MASK;
		end
		// ac excitation: flip phase every other data-ready, giving fdr/4
		if (data_ready_i) begin
			next_q.ac_cnt = q.ac_cnt + 2'h1;
			if (q.ac_cnt == 2'(`MGL_AC_PHASE_DIV - 1)) begin
				next_q.ac_cnt = 2'h0;
				next_q.ac_phase = !q.ac_phase;
			end
		end
		// register writes; reserved bits masked so they read back zero
		if (bus.wr_en) begin
			case (bus.addr)
				`MGL_OFF_MISC_CONTROL_TWO: next_q.misc = bus.wdata & `MGL_MISC_MASK;
				`MGL_OFF_GENERAL_PIN_CONTROL: begin
					next_q.pins = bus.wdata & `MGL_PIN_MASK;
				end
				`MGL_OFF_ELECTRODE_SENSE: next_q.sense = bus.wdata & `MGL_SENSE_MASK;
				`MGL_OFF_DRIVE_SENSE: next_q.drive = bus.wdata & `MGL_DRIVE_MASK;
				`MGL_OFF_CONFIG_TWO: next_q.cfg2 = bus.wdata;
				`MGL_OFF_DETECT_CONTROL: next_q.det = bus.wdata;
				default: ;
			endcase
		end
		// output latch only follows writes for pins set as outputs
		for (int i = 0; i < 2; i++) begin
			next_q.pin_oe[i] = !next_q.pins[`MGL_PIN_DIR_LO + i];
			if (!next_q.pins[`MGL_PIN_DIR_LO + i]) begin
				next_q.pin_out[i] = next_q.pins[`MGL_PIN_DATA_LO + i];
			end
		end
		// sensing may stay on while excitation is off (drive sense bit gates excitation)
		next_q.sense_en = next_q.sense[3:0];
		next_q.excite_en = next_q.drive[`MGL_DRIVE_SENSE_BIT] ? 4'h0 : next_q.sense[3:0];
		// sink only useful while the drive amp is off
		next_q.sink_en = next_q.drive[`MGL_DRIVE_SENSE_BIT] && !next_q.drive[`MGL_DRIVE_PWR_BIT];
		// rerouting of the return input onto a channel side
		next_q.r1 = {ch1_select_i == `MGL_MUX_DRIVE_NEG, ch1_select_i == `MGL_MUX_DRIVE_POS};
		next_q.r2 = {ch2_select_i == `MGL_MUX_DRIVE_NEG, ch2_select_i == `MGL_MUX_DRIVE_POS};
		// reads answer one cycle after the strobe
		next_q.rvalid = bus.rd_en;
		next_q.rdata = 8'h00;
		if (bus.rd_en) begin
			case (bus.addr)
				`MGL_OFF_MISC_CONTROL_TWO: next_q.rdata = q.misc;
				`MGL_OFF_GENERAL_PIN_CONTROL: next_q.rdata = {4'h0, q.pins[3:2], q.pin_level};
				`MGL_OFF_ELECTRODE_SENSE: next_q.rdata = q.sense;
				`MGL_OFF_DRIVE_SENSE: next_q.rdata = q.drive;
				`MGL_OFF_CONFIG_TWO: next_q.rdata = q.cfg2;
				`MGL_OFF_DETECT_CONTROL: next_q.rdata = q.det;
				`MGL_OFF_ELECTRODE_STATUS: next_q.rdata = q.status;
				default: next_q.rdata = 8'h00;
			endcase
		end
		// the ac phase keeps running in every mode, so it is already settled when
		// ac excitation is picked; only the analog side decides whether it is used.
		// trade-off: a little toggling power in dc mode for no start-up glitch,
		// and the sense and excitation enables above stay the final values here
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.pins <= `MGL_PIN_RESET;
			q.cfg2 <= `MGL_CFG2_RESET;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================
	// outputs, all straight from flops
	assign bus.rdata = q.rdata;
	assign bus.rvalid = q.rvalid;
	assign pin_out_o = q.pin_out;
	assign pin_oe_o = q.pin_oe;
	assign offset_cal_enable_o = q.misc[`MGL_MISC_CAL_BIT];
	assign drive_ref_internal_sel_o = q.misc[`MGL_MISC_REF_BIT];
	assign sense_enable_o = q.sense_en;
	assign excite_enable_o = q.excite_en;
	assign excitation_direction_swap_o = q.sense[5:4];
	assign excitation_current_level_o = q.det[`MGL_DET_LEVEL_LO +: 2];
	assign comparator_threshold_sel_o = q.det[`MGL_DET_TH_LO +: 3];
	assign comparator_powerdown_o = q.cfg2[`MGL_CFG2_CMP_PD_BIT];
	assign excite_polarity_o = q.ac_phase;
	assign drive_sink_enable_o = q.sink_en;
	assign ch1_route_o = q.r1;
	assign ch2_route_o = q.r2;
	assign stream_status_o = q.status;
	assign stream_control_o = q.det;
endmodule

// ---- rtl/mgl_defines.svh ----
// register offsets, field positions and reset values for the misc/pin/electrode-detect block
// assumes 8-bit registers addressed by a small offset over the serial port
`ifndef MGL_DEFINES_SVH
`define MGL_DEFINES_SVH
`define MGL_ADDR_W 5
`define MGL_OFF_CONFIG_TWO 5'h02
`define MGL_OFF_DETECT_CONTROL 5'h04
`define MGL_OFF_DRIVE_SENSE 5'h06
`define MGL_OFF_ELECTRODE_SENSE 5'h07
`define MGL_OFF_ELECTRODE_STATUS 5'h08
`define MGL_OFF_MISC_CONTROL_TWO 5'h0a
`define MGL_OFF_GENERAL_PIN_CONTROL 5'h0b
`define MGL_OFF_CH1_SET 5'h04
`define MGL_OFF_CH2_SET 5'h05
`define MGL_MISC_CAL_BIT 7
`define MGL_MISC_REF_BIT 1
`define MGL_MISC_MASK 8'h82
`define MGL_PIN_MASK 8'h0f
`define MGL_PIN_DIR_LO 2
`define MGL_PIN_DATA_LO 0
`define MGL_PIN_RESET 8'h0c
`define MGL_SENSE_MASK 8'h3f
`define MGL_DRIVE_MASK 8'h3f
`define MGL_DRIVE_PWR_BIT 5
`define MGL_DRIVE_SENSE_BIT 4
`define MGL_CFG2_CMP_PD_BIT 6
`define MGL_CFG2_RESET 8'h80
`define MGL_DET_LEVEL_LO 2
`define MGL_DET_TH_LO 5
`define MGL_DET_AC_BIT 0
`define MGL_STATUS_MASK 8'h1f
`define MGL_MUX_DRIVE_POS 4'h6
`define MGL_MUX_DRIVE_NEG 4'h7
`define MGL_AC_PHASE_DIV 2
`endif

// ---- rtl/mgl_pkg.sv ----
// types shared by both ends of the misc/pin/electrode-detect block
// assumes mgl_defines.svh is on the include path
package mgl_pkg;
	typedef logic [7:0] mgl_byte_t;
	typedef logic [4:0] mgl_addr_t;
	typedef enum logic [1:0] {MGL_H_IDLE, MGL_H_WRITE, MGL_H_READ} mgl_host_state_e;
endpackage

// ---- rtl/mgl_if.sv ----
// register access carrier between the host end and the device end
// assumes both ends share clk_sys_i; one access per cycle strobe
`timescale 1ns/1ps
interface mgl_if;
	import mgl_pkg::*;
	logic wr_en;
	logic rd_en;
	mgl_addr_t addr;
	mgl_byte_t wdata;
	mgl_byte_t rdata;
	logic rvalid;
	modport dev (input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
	modport host (output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface

// ---- rtl/mgl_host.sv ----
// host end: issues one register write or read per command and returns read data
// assumes the device answers a read exactly one cycle after the strobe
`timescale 1ns/1ps
`include "mgl_defines.svh"
module mgl_host (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// user command port
	input wire logic cmd_valid_i,
	input wire logic cmd_write_i,
	input wire mgl_pkg::mgl_addr_t cmd_addr_i,
	input wire mgl_pkg::mgl_byte_t cmd_wdata_i,
	output logic cmd_ready_o,
	output logic rsp_valid_o,
	output mgl_pkg::mgl_byte_t rsp_data_o,
	// register access
	mgl_if.host bus
);
	import mgl_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		mgl_host_state_e st;
		logic wr_en;
		logic rd_en;
		mgl_addr_t addr;
		mgl_byte_t wdata;
		logic ready;
		logic rsp_valid;
		mgl_byte_t rsp_data;
	} mgl_host_s;

	mgl_host_s q;
	mgl_host_s next_q;

	// ==========================================
	// command sequencing
	always_comb begin
		next_q = q;
		next_q.wr_en = 1'b0;
		next_q.rd_en = 1'b0;
		next_q.rsp_valid = 1'b0;
		case (q.st)
			MGL_H_IDLE: begin
				if (cmd_valid_i && q.ready) begin
					next_q.addr = cmd_addr_i;
					next_q.ready = 1'b0;
					if (cmd_write_i) begin
						next_q.wr_en = 1'b1;
						next_q.st = MGL_H_WRITE;
						// reserved bits forced to zero on misc and pin registers
						case (cmd_addr_i)
							`MGL_OFF_MISC_CONTROL_TWO: next_q.wdata = cmd_wdata_i & `MGL_MISC_MASK;
							`MGL_OFF_GENERAL_PIN_CONTROL: next_q.wdata = cmd_wdata_i & `MGL_PIN_MASK;
							default: next_q.wdata = cmd_wdata_i;
						endcase
					end else begin
						next_q.rd_en = 1'b1;
						next_q.st = MGL_H_READ;
					end
				end
			end
			MGL_H_WRITE: begin
				next_q.st = MGL_H_IDLE;
				next_q.ready = 1'b1;
			end
			MGL_H_READ: begin
				if (bus.rvalid) begin
					next_q.rsp_valid = 1'b1;
					next_q.rsp_data = bus.rdata;
					next_q.st = MGL_H_IDLE;
					next_q.ready = 1'b1;
				end
			end
			default: next_q.st = MGL_H_IDLE;
		endcase
	end

	// ==========================================
	// registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.st <= MGL_H_IDLE;
			q.ready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign bus.wr_en = q.wr_en;
	assign bus.rd_en = q.rd_en;
	assign bus.addr = q.addr;
	assign bus.wdata = q.wdata;
	assign cmd_ready_o = q.ready;
	assign rsp_valid_o = q.rsp_valid;
	assign rsp_data_o = q.rsp_data;
endmodule

// ---- tb/mgl_asserts.sv ----
// checker for the register carrier between host end and device end
// assumes one clock, synchronous active-high reset, host spacing of two cycles after a write
`timescale 1ns/1ps
module mgl_asserts (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// carrier signals
	input wire logic wr_en,
	input wire logic rd_en,
	input wire mgl_pkg::mgl_addr_t addr,
	input wire mgl_pkg::mgl_byte_t wdata,
	input wire mgl_pkg::mgl_byte_t rdata,
	input wire logic rvalid
);
	import mgl_pkg::*;
	// ==========================================
	// read timing and masking
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	a_read_answer: assert property (rd_en |=> rvalid) else $error("read not answered next cycle");
	a_no_stray_valid: assert property (rvalid |-> $past(rd_en)) else $error("valid without read");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !rvalid) else $error("valid during reset");
	a_misc_zero_bits: assert property (rd_en && addr == 5'h0a |=> (rdata & 8'h7d) == 8'h00)
		else $error("misc reserved bits set");
	a_pin_zero_bits: assert property (rd_en && addr == 5'h0b |=> rdata[7:4] == 4'h0)
		else $error("pin upper bits set");
	a_status_zero_bits: assert property (rd_en && addr == 5'h08 |=> (rdata & 8'he0) == 8'h00)
		else $error("status spare bits set");
	a_unmapped_zero: assert property (rd_en && addr > 5'h0b |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	// ==========================================
	// write then read back through the host spacing
	a_misc_readback: assert property (wr_en && addr == 5'h0a ##2 rd_en && addr == 5'h0a
		|=> rdata == ($past(wdata, 3) & 8'h82)) else $error("misc readback wrong");
	a_dir_readback: assert property (wr_en && addr == 5'h0b ##2 rd_en && addr == 5'h0b
		|=> (rdata & 8'h0c) == ($past(wdata, 3) & 8'h0c)) else $error("direction readback wrong");
endmodule

// ---- tb/tb.sv ----
// self-checking bench: host end and device end joined by the carrier
// assumes rtl/ on the include path; pin wire level resolved here from both drivers
`timescale 1ns/1ps
module tb;
	import mgl_pkg::*;
	typedef struct {mgl_addr_t a; mgl_byte_t d; mgl_byte_t e;} mgl_row_s;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic cmd_valid = 1'b0, cmd_write = 1'b0, dr = 1'b0, dcmp = 1'b0;
	mgl_addr_t cmd_addr = '0;
	mgl_byte_t cmd_wdata = '0, got;
	logic [1:0] ext = 2'b00, pout, poe, swp, lvl, r1, r2;
	logic [3:0] ecmp = 4'h0, s1 = 4'h0, s2 = 4'h0, sen, exc;
	logic cal, rsel, pd, pol, p0, sink, rdy, rspv;
	logic [2:0] th;
	mgl_byte_t sst, sctl, rspd;
	int failures = 0, cmp_count = 0;
	mgl_row_s rows[7] = '{'{5'h0a, 8'h80, 8'h80}, '{5'h0a, 8'h02, 8'h02}, '{5'h0a, 8'hff, 8'h82},
		'{5'h07, 8'hff, 8'h3f}, '{5'h06, 8'hff, 8'h3f}, '{5'h0b, 8'hfc, 8'h0c}, '{5'h1f, 8'h5a, 8'h00}};
	// inputs are pins: a driven pin shows its own level, otherwise the outside level
	wire logic [1:0] pin_lvl = (poe & pout) | (~poe & ext);
	always #2.5 clk_sys_i = ~clk_sys_i;
	mgl_if bus_if ();
	mgl_host mgl_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
		.cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(rdy), .rsp_valid_o(rspv),
		.rsp_data_o(rspd), .bus(bus_if));
	mgl_device mgl_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(bus_if), .pin_in_i(pin_lvl),
		.pin_out_o(pout), .pin_oe_o(poe), .electrode_cmp_i(ecmp), .drive_cmp_i(dcmp), .data_ready_i(dr),
		.ch1_select_i(s1), .ch2_select_i(s2), .offset_cal_enable_o(cal), .drive_ref_internal_sel_o(rsel),
		.sense_enable_o(sen), .excite_enable_o(exc), .excitation_direction_swap_o(swp),
		.excitation_current_level_o(lvl), .comparator_threshold_sel_o(th), .comparator_powerdown_o(pd),
		.excite_polarity_o(pol), .drive_sink_enable_o(sink), .ch1_route_o(r1), .ch2_route_o(r2),
		.stream_status_o(sst), .stream_control_o(sctl));
	mgl_asserts mgl_asserts_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid));
	// ==========================================
	// tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one command, held until the edge that takes it; waits for ready again
	task automatic cmd(input logic w, input mgl_addr_t a, input mgl_byte_t d);
		int n;
		n = 0;
		while (rdy !== 1'b1 && n < 50) begin
			@(negedge clk_sys_i);
			n++;
		end
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_valid = 1'b1;
		@(negedge clk_sys_i);
		cmd_valid = 1'b0;
		n = 0;
		while (((w && rdy !== 1'b1) || (!w && rspv !== 1'b1)) && n < 50) begin
			@(negedge clk_sys_i);
			n++;
		end
		if (n == 50) failures++;
		got = rspd;
	endtask
	task automatic rd_chk(input mgl_addr_t a, input mgl_byte_t e);
		cmd(1'b0, a, 8'h00);
		chk(got, e);
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			dr = 1'b1;
			wt(1);
			dr = 1'b0;
			wt(3);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		failures++;
		summarize;
	end
	// ==========================================
	// main sequence
	initial begin
		repeat (12) @(negedge clk_sys_i);
		rst_i = 1'b0;
		foreach (rows[i]) begin
			cmd(1'b1, rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].e);
		end
		$display("test table done");
		rst_i = 1'b1;
		wt(3);
		rst_i = 1'b0;
		rd_chk(5'h0a, 8'h00);
		rd_chk(5'h0b, 8'h0c);
		rd_chk(5'h06, 8'h00);
		rd_chk(5'h02, 8'h80);
		chk({7'h0, pd}, 8'h00);
		chk({6'h0, poe}, 8'h00);
		chk({7'h0, pol}, 8'h00);
		p0 = pol;
		pulse(2);
		chk({7'h0, pol}, {7'h0, ~p0});
		pulse(1);
		chk({7'h0, pol}, {7'h0, ~p0});
		pulse(1);
		chk({7'h0, pol}, {7'h0, p0});
		$display("test reset and ac phase done");
		cmd(1'b1, 5'h0a, 8'h82);
		chk({6'h0, cal, rsel}, 8'h03);
		cmd(1'b1, 5'h07, 8'h3f);
		chk({sen, exc}, 8'hff);
		chk({6'h0, swp}, 8'h03);
		cmd(1'b1, 5'h06, 8'h10);
		chk({sen, exc}, 8'hf0);
		chk({7'h0, sink}, 8'h01);
		cmd(1'b1, 5'h06, 8'h30);
		chk({7'h0, sink}, 8'h00);
		cmd(1'b1, 5'h04, 8'he4);
		chk({3'h0, th, lvl}, 8'h1d);
		chk(sctl, 8'he4);
		ecmp = 4'b0101;
		wt(8);
		rd_chk(5'h08, 8'h05);
		chk(sst, 8'h05);
		cmd(1'b1, 5'h02, 8'hc0);
		chk({7'h0, pd}, 8'h01);
		wt(8);
		rd_chk(5'h08, 8'h00);
		$display("test controls and status done");
		ext = 2'b10;
		cmd(1'b1, 5'h0b, 8'h0f);
		chk({6'h0, poe}, 8'h00);
		wt(6);
		rd_chk(5'h0b, 8'h0e);
		cmd(1'b1, 5'h0b, 8'h01);
		chk({4'h0, poe, pout}, 8'h0d);
		wt(6);
		rd_chk(5'h0b, 8'h01);
		cmd(1'b1, 5'h0b, 8'h09);
		wt(6);
		rd_chk(5'h0b, 8'h0b);
		s1 = 4'h6;
		s2 = 4'h7;
		wt(2);
		chk({4'h0, r2, r1}, 8'h09);
		$display("test pins and routing done");
		summarize;
	end
endmodule
